//--- logic/drs_device.sv
// Device end: register bank, readback path, power-on load, switch decode.
//
// Implementation choice: the plain strobed port.
`default_nettype none
// Summary of operation
// - Every mapped register reads back; calibrated code never.
// - Host read request: flag 1, address, zero data.
// - Requested word shifts out on next transfer.
// - Offsets comparator_alarm_status and alarm_status_and_clear are read-only.
// - Reading alarm_status_and_clear clears latched alarms and pins.
// - DAC code, gain, offset registers read back.
// - Host clocks readback transfers slower than writes.
// - Power-on loads defaults, busy low until done.
// - Reset pin ignored during power-on load.
// - Codes zero volts except comparator high at full scale, gain full, offset mid scale.
// - Reset function restores the power-on defaults.
// - Inhibit selects position c; otherwise gang code 2 selects c, gang code 3 selects b, and the other codes select a.
// - Master gang codes route master output path.
// - Slave gang codes open 5, close 6.
// - Range code sets switches 4, 7, 13-15.
module drs_device
  import drs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Serial link.
  drs_if.device link,
  // Pins and analog status.
  input wire logic reset_pin_n_in,
  input wire logic hw_inhibit_n_in,
  input wire logic comp_high_in,
  input wire logic comp_low_in,
  input wire logic [ALARM_N-1:0] alarm_event_in,
  // Switch controls and open-drain alarm pins.
  output logic [1:0] sw01_pos_out,
  output logic [1:0] sw02_pos_out,
  output logic [1:0] sw05_pos_out,
  output logic [SWC_N-1:0] sw_closed_out,
  output logic [2:0] alarm_pin_oe_out,
  output logic [2:0] alarm_pin_out
);
  typedef enum logic {POR_LOAD, POR_READY} drs_por_e;

  localparam int EXT_W = 12;
  logic [EXT_W-1:0] ext_meta_ff;
  logic [EXT_W-1:0] ext_ff;
  logic sclk_prev_ff;
  logic sync_prev_ff;
  drs_por_e state_ff;
  logic [6:0] por_cnt_ff;
  logic busy_n_ff;
  logic [FRAME_BITS-1:0] in_sr_ff;
  logic [FRAME_BITS-1:0] out_sr_ff;
  logic [4:0] bit_cnt_ff;
  logic [15:0] regs_ff [REG_COUNT];
  logic [ALARM_N-1:0] alm_lat_ff;
  logic [ALARM_N-1:0] nxt_alm_lat;
  logic [15:0] rd_value;
  logic [15:0] alarm_word;

  // Default value of each register after power-on or reset function.
  function automatic logic [15:0] reg_default(input int idx);
    case (idx)
      REG_FORCE_M, REG_CPL_M, REG_CPH_M: reg_default = RST_GAIN_FULL;
      REG_FORCE_C, REG_CPL_C, REG_CPH_C: reg_default = RST_OFFSET_ZERO;
      REG_FORCE_X1, REG_CPL_X1: reg_default = RST_X1_ZERO_V;
      REG_CPH_X1: reg_default = RST_CPH_X1;
      default: reg_default = RST_ZERO;
    endcase
  endfunction

  // Two-stage synchroniser for every input from outside the clock domain.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Idle levels: reset pin, inhibit pin and frame select high.
      ext_meta_ff <= 12'hc02;
      ext_ff <= 12'hc02;
    end else begin
      ext_meta_ff <= {reset_pin_n_in, hw_inhibit_n_in, comp_high_in,
                      comp_low_in, alarm_event_in, link.sclk,
                      link.sync_n, link.sdi};
      ext_ff <= ext_meta_ff;
    end
  end

  wire logic rst_pin_n = ext_ff[11];
  wire logic hardware_output_inhibit_pin_n = ext_ff[10];
  wire logic cph = ext_ff[9];
  wire logic cpl = ext_ff[8];
  wire logic [ALARM_N-1:0] alm_now = ext_ff[7:3];
  wire logic sclk_s = ext_ff[2];
  wire logic sync_n_s = ext_ff[1];
  wire logic sdi_s = ext_ff[0];
  wire logic sclk_rise = sclk_s && !sclk_prev_ff;
  wire logic sclk_fall = !sclk_s && sclk_prev_ff;
  wire logic sync_rise = sync_n_s && !sync_prev_ff;
  wire logic sync_fall = !sync_n_s && sync_prev_ff;
  wire logic ready = (state_ff == POR_READY);
  wire logic frame_done = sync_rise && ready && (bit_cnt_ff == FRAME_COUNT);
  wire logic f_rw = in_sr_ff[FRAME_RW_BIT];
  wire logic [6:0] f_addr = in_sr_ff[FRAME_ADDR_LSB +: ADDR_W];
  wire logic [15:0] f_data = in_sr_ff[15:0];
  wire logic rd_req = frame_done && f_rw;
  wire logic wr_req = frame_done && !f_rw;

  // Edge history of the synchronised link signals.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_prev_ff <= 1'b0;
      sync_prev_ff <= 1'b1;
    end else begin
      sclk_prev_ff <= sclk_s;
      sync_prev_ff <= sync_n_s;
    end
  end

  // power-on sequencer; the reset pin only acts once ready.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= POR_LOAD;
      por_cnt_ff <= 7'h00;
      busy_n_ff <= 1'b0;
    end else begin
      case (state_ff)
        POR_LOAD: begin
          por_cnt_ff <= por_cnt_ff + 7'h01;
          if (por_cnt_ff == 7'(POR_CYCLES - 1)) begin
            state_ff <= POR_READY;
          end
        end
        POR_READY: begin
          // reset function re-runs the default load.
          if (!rst_pin_n) begin
            state_ff <= POR_LOAD;
            por_cnt_ff <= 7'h00;
          end
        end
        default: state_ff <= POR_LOAD;
      endcase
      busy_n_ff <= ready && rst_pin_n;
    end
  end

  // Input shift register and bit count, captured on rising serial clock.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_sr_ff <= '0;
      bit_cnt_ff <= 5'h00;
    end else if (sync_fall) begin
      bit_cnt_ff <= 5'h00;
    end else if (sclk_rise && !sync_n_s) begin
      in_sr_ff <= {in_sr_ff[FRAME_BITS-2:0], sdi_s};
      if (bit_cnt_ff != FRAME_COUNT) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
    end
  end

  // registers take defaults; read-only offsets not stored.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_ff[i] <= reg_default(i);
      end
    end else if (!ready) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_ff[i] <= reg_default(i);
      end
    end else if (wr_req && (int'(f_addr) < REG_COUNT) &&
                 (f_addr != REG_COMP_STATUS) &&
                 (f_addr != REG_ALARM_STATUS)) begin
      regs_ff[f_addr] <= f_data;
    end
  end

  // Alarm status word: latched and live bits, low while alarmed.
  always_comb begin
    alarm_word = 16'h0000;
    for (int k = 0; k < ALARM_N; k++) begin
      alarm_word[15 - 2 * k] = !alm_lat_ff[k];
      alarm_word[14 - 2 * k] = !alm_now[k];
    end
    alarm_word[STAT_CPOL_BIT] = cpl;
    alarm_word[STAT_CPOH_BIT] = cph;
  end

  // every mapped register reads back; no calibrated code exists.
  always_comb begin
    rd_value = 16'h0000;
    if (f_addr == REG_ALARM_STATUS) begin
      rd_value = alarm_word;
    end else if (f_addr == REG_COMP_STATUS) begin
      rd_value[STAT_CPOL_BIT] = cpl;
      rd_value[STAT_CPOH_BIT] = cph;
    end else if (int'(f_addr) < REG_COUNT) begin
      rd_value = regs_ff[f_addr];
    end
  end

  // alarm read clears latches; a new event beats the clear.
  always_comb begin
    nxt_alm_lat = alm_lat_ff;
    if (rd_req && (f_addr == REG_ALARM_STATUS)) begin
      nxt_alm_lat = '0;
    end
    if (!ready) begin
      nxt_alm_lat = '0;
    end
    nxt_alm_lat = nxt_alm_lat | alm_now;
  end

  // Latched alarms and the open-drain pins they pull low.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alm_lat_ff <= '0;
      alarm_pin_oe_out <= 3'h0;
      alarm_pin_out <= 3'h0;
    end else begin
      alm_lat_ff <= nxt_alm_lat;
      alarm_pin_oe_out <= {alm_lat_ff[ALM_CLAMP], alm_lat_ff[ALM_KELVIN],
                           alm_lat_ff[ALM_TEMP]};
      alarm_pin_out <= 3'h0;
    end
  end

  // requested word loads at frame end, shifts out on falling clock.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_sr_ff <= '0;
    end else if (rd_req) begin
      out_sr_ff <= {8'h00, rd_value};
    end else if (wr_req) begin
      out_sr_ff <= '0;
    end else if (sclk_fall && !sync_n_s) begin
      out_sr_ff <= {out_sr_ff[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign link.sdo = out_sr_ff[FRAME_BITS-1];
  assign link.busy_n = busy_n_ff;

  wire logic [15:0] sys = regs_ff[REG_SYS_CTRL];
  wire logic [15:0] dps1 = regs_ff[REG_DPS1];
  wire logic [15:0] dps2 = regs_ff[REG_DPS2];
  wire logic [2:0] range = dps1[DPS1_RANGE_LSB +: 3];
  wire logic [1:0] gang = dps2[DPS2_GANG_LSB +: 2];
  wire logic slave = gang[1];

  // Switch decode from the control registers.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sw01_pos_out <= POS_B;
      sw02_pos_out <= POS_C;
      sw05_pos_out <= POS_A;
      sw_closed_out <= '0;
    end else begin
      // force-ground select, unless a gang slave takes position c.
      sw01_pos_out <= slave ? POS_C :
                      (sys[SYS_FORCE_GND_BIT] ? POS_A : POS_B);
      // inhibit by bit or pin parks the amplifier at position c.
      if (!dps1[DPS1_SW_INHIBIT_BIT] || !hardware_output_inhibit_pin_n) begin
        sw02_pos_out <= POS_C;
      end else begin
        sw02_pos_out <= (gang == 2'h2) ? POS_C :
                        ((gang == 2'h3) ? POS_B : POS_A);
      end
      // master codes route the gang output; slaves open it.
      sw05_pos_out <= slave ? POS_OPEN : (gang[0] ? POS_B : POS_A);
      sw_closed_out[SWC_06] <= slave;
      sw_closed_out[SWC_04] <= (range <= 3'h4);
      sw_closed_out[SWC_07] <= (range <= 3'h4);
      sw_closed_out[SWC_13] <= (range == 3'h6);
      sw_closed_out[SWC_14] <= (range == 3'h5);
      sw_closed_out[SWC_15] <= (range == 3'h5) || (range == 3'h6);
      sw_closed_out[SWC_16] <= (dps1[DPS1_MEASURE_LSB +: 3] != 3'h0);
      sw_closed_out[SWC_08] <= dps2[DPS2_PAIR_BIT];
      sw_closed_out[SWC_09] <= dps2[DPS2_PAIR_BIT];
      sw_closed_out[SWC_11] <= dps2[DPS2_RES_BIT];
    end
  end
endmodule
`default_nettype wire

//--- logic/drs_host.sv
// Host end: command registers and the serial frame generator.
`default_nettype none
module drs_host
  import drs_pkg::*;
#(
  parameter int HALF_WR = HALF_WRITE,
  parameter int HALF_RD = HALF_READ
)
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Serial link.
  drs_if.host link,
  // Software command port.
  input wire logic [2:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL} drs_host_e;

  drs_host_e state_ff;
  logic [1:0] meta_ff;
  logic [1:0] in_ff;
  logic [15:0] data_ff;
  logic [15:0] rx_ff;
  logic [FRAME_BITS-1:0] tx_sr_ff;
  logic [15:0] rx_sr_ff;
  logic [4:0] bit_ff;
  logic [7:0] div_ff;
  logic [7:0] half_ff;
  logic collect_ff;
  logic sclk_ff;
  logic sync_n_ff;

  wire logic sdo_s = in_ff[0];
  wire logic dev_ready = in_ff[1];
  wire logic half_done = (div_ff == half_ff - 8'h01);
  wire logic start = wr_in && (addr_in == HREG_CMD) &&
                     (state_ff == H_IDLE) && dev_ready;

  // Two-stage synchroniser for data out and busy from the device.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_ff <= 2'h0;
      in_ff <= 2'h0;
    end else begin
      meta_ff <= {link.busy_n, link.sdo};
      in_ff <= meta_ff;
    end
  end

  // Data register and software read port, data one cycle after strobe.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_ff <= 16'h0000;
      rdata_out <= 16'h0000;
    end else begin
      if (wr_in && (addr_in == HREG_DATA)) begin
        data_ff <= wdata_in;
      end
      if (rd_in) begin
        case (addr_in)
          HREG_DATA: rdata_out <= data_ff;
          HREG_STATUS: rdata_out <= {13'h0000, collect_ff, dev_ready,
                                     state_ff != H_IDLE};
          HREG_RX: rdata_out <= rx_ff;
          default: rdata_out <= 16'h0000;
        endcase
      end else begin
        rdata_out <= 16'h0000;
      end
    end
  end

  // Frame generator; no frame starts while the device is busy.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= H_IDLE;
      tx_sr_ff <= '0;
      rx_sr_ff <= 16'h0000;
      rx_ff <= 16'h0000;
      bit_ff <= 5'h00;
      div_ff <= 8'h00;
      half_ff <= 8'(HALF_WR);
      collect_ff <= 1'b0;
      sclk_ff <= 1'b0;
      sync_n_ff <= 1'b1;
    end else begin
      div_ff <= half_done ? 8'h00 : div_ff + 8'h01;
      case (state_ff)
        H_IDLE: begin
          div_ff <= 8'h00;
          if (start) begin
            // a read request carries all-zero data.
            tx_sr_ff <= {wdata_in[7], wdata_in[6:0],
                         wdata_in[7] ? 16'h0000 : data_ff};
            // request and collection frames run the slow clock.
            half_ff <= (wdata_in[7] || collect_ff) ? 8'(HALF_RD) :
                       8'(HALF_WR);
            collect_ff <= wdata_in[7];
            bit_ff <= 5'h00;
            sync_n_ff <= 1'b0;
            state_ff <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_done) begin
            sclk_ff <= 1'b1;
            state_ff <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_done) begin
            // collect the device's word at the end of each high phase.
            rx_sr_ff <= {rx_sr_ff[14:0], sdo_s};
            tx_sr_ff <= {tx_sr_ff[FRAME_BITS-2:0], 1'b0};
            sclk_ff <= 1'b0;
            bit_ff <= bit_ff + 5'h01;
            state_ff <= (bit_ff == FRAME_LAST) ? H_TAIL : H_LOW;
          end
        end
        H_TAIL: begin
          sync_n_ff <= 1'b1;
          rx_ff <= rx_sr_ff;
          if (half_done) begin
            state_ff <= H_IDLE;
          end
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_ff;
  assign link.sync_n = sync_n_ff;
  assign link.sdi = tx_sr_ff[FRAME_BITS-1];
endmodule
`default_nettype wire

//--- pkg/drs_if.sv
// Four-wire serial link with busy flag between host and device.
`default_nettype none
interface drs_if;
  logic sclk;
  logic sync_n;
  logic sdi;
  logic sdo;
  logic busy_n;
  modport device (input sclk, input sync_n, input sdi,
                  output sdo, output busy_n);
  modport host (output sclk, output sync_n, output sdi,
                input sdo, input busy_n);
endinterface
`default_nettype wire

//--- pkg/drs_pkg.sv
// Shared constants for the power supply readback and switch control link.
`default_nettype none
package drs_pkg;
  // Serial frame layout: read/write flag, register address, data word.
  localparam int FRAME_BITS = 24;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int FRAME_RW_BIT = 23;
  localparam int FRAME_ADDR_LSB = 16;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] FRAME_COUNT = 5'h18;

  // Device register offsets.
  localparam logic [6:0] REG_SYS_CTRL = 7'h01;
  localparam logic [6:0] REG_DPS1 = 7'h02;
  localparam logic [6:0] REG_DPS2 = 7'h03;
  localparam logic [6:0] REG_FORCE_X1 = 7'h08;
  localparam logic [6:0] REG_FORCE_M = 7'h09;
  localparam logic [6:0] REG_FORCE_C = 7'h0a;
  localparam logic [6:0] REG_COMP_STATUS = 7'h43;
  localparam logic [6:0] REG_ALARM_STATUS = 7'h44;
  localparam logic [6:0] REG_CPL_X1 = 7'h45;
  localparam logic [6:0] REG_CPL_M = 7'h46;
  localparam logic [6:0] REG_CPL_C = 7'h47;
  localparam logic [6:0] REG_CPH_X1 = 7'h48;
  localparam logic [6:0] REG_CPH_M = 7'h49;
  localparam logic [6:0] REG_CPH_C = 7'h4a;
  localparam int REG_COUNT = 75;

  // Values after reset.
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_X1_ZERO_V = 16'h0000;
  localparam logic [15:0] RST_GAIN_FULL = 16'hffff;
  localparam logic [15:0] RST_OFFSET_ZERO = 16'h8000;
  localparam logic [15:0] RST_CPH_X1 = 16'hffff;

  // Field positions in the control registers.
  localparam int SYS_FORCE_GND_BIT = 0;
  localparam int DPS1_SW_INHIBIT_BIT = 15;
  localparam int DPS1_RANGE_LSB = 10;
  localparam int DPS1_MEASURE_LSB = 4;
  localparam int DPS2_PAIR_BIT = 0;
  localparam int DPS2_GANG_LSB = 1;
  localparam int DPS2_RES_BIT = 3;

  // Alarm sources and status layout.
  localparam int ALARM_N = 5;
  localparam int ALM_TEMP = 0;
  localparam int ALM_KELVIN = 2;
  localparam int ALM_CLAMP = 3;
  localparam int STAT_CPOL_BIT = 5;
  localparam int STAT_CPOH_BIT = 4;

  // Switch positions and closed-switch vector indices.
  localparam logic [1:0] POS_A = 2'h0;
  localparam logic [1:0] POS_B = 2'h1;
  localparam logic [1:0] POS_C = 2'h2;
  localparam logic [1:0] POS_OPEN = 2'h3;
  localparam int SWC_N = 10;
  localparam int SWC_04 = 0;
  localparam int SWC_06 = 1;
  localparam int SWC_07 = 2;
  localparam int SWC_08 = 3;
  localparam int SWC_09 = 4;
  localparam int SWC_11 = 5;
  localparam int SWC_13 = 6;
  localparam int SWC_14 = 7;
  localparam int SWC_15 = 8;
  localparam int SWC_16 = 9;

  // Power-on load time and serial clock half periods, in clk cycles.
  localparam int POR_CYCLES = 64;
  localparam int HALF_WRITE = 2;
  localparam int HALF_READ = 4;

  // Host command port register offsets.
  localparam logic [2:0] HREG_DATA = 3'h0;
  localparam logic [2:0] HREG_CMD = 3'h1;
  localparam logic [2:0] HREG_STATUS = 3'h2;
  localparam logic [2:0] HREG_RX = 3'h3;
endpackage
`default_nettype wire

//--- sim/drs_monitor.sv
// Checker for the four-wire link between the host and device ends.
`default_nettype none
module drs_monitor #(
  parameter int HALF_RD = 4
)
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Link signals.
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic sdi_in,
  input wire logic sdo_in,
  input wire logic busy_n_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sclk_ff;
  logic sync_ff;
  logic rw_ff;
  logic prev_rd_ff;
  logic [4:0] edge_ff;
  logic [3:0] hi_ff;
  logic [7:0] busy_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // Delayed copies of the clock and frame-select lines, used to find their edges.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_ff <= 1'b0;
      sync_ff <= 1'b1;
    end else begin
      sclk_ff <= sclk_in;
      sync_ff <= sync_n_in;
    end
  end

  // Frame kind, previous frame kind and count of rising clock edges.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      edge_ff <= 5'h00;
      rw_ff <= 1'b0;
      prev_rd_ff <= 1'b0;
    end else if (sync_ff && !sync_n_in) begin
      edge_ff <= 5'h00;
      rw_ff <= sdi_in;
      prev_rd_ff <= rw_ff;
    end else if (!sync_n_in && sclk_in && !sclk_ff) begin
      edge_ff <= edge_ff + 5'h01;
    end
  end

  // Length of the current clock high phase and of the busy period.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hi_ff <= 4'h0;
      busy_ff <= 8'h00;
    end else begin
      hi_ff <= sclk_in ? hi_ff + 4'h1 : 4'h0;
      if (busy_n_in) begin
        busy_ff <= 8'h00;
      end else if (busy_ff != 8'hff) begin
        busy_ff <= busy_ff + 8'h01;
      end
    end
  end

  a_busy_load_len:
    assert property ($rose(busy_n_in) |->
                     busy_ff >= 8'h3f && busy_ff <= 8'h46)
    else $error("busy period has the wrong length");
  a_no_start_busy:
    assert property ($fell(sync_n_in) |-> busy_n_in)
    else $error("frame started while busy");
  a_host_waits:
    assert property ($rose(busy_n_in) |-> sync_n_in [*3])
    else $error("frame started too soon after busy");
  a_frame_len_24:
    assert property ($rose(sync_n_in) |-> edge_ff == 5'h18)
    else $error("frame without 24 clock edges");
  a_read_slow_clk:
    assert property ($fell(sclk_in) && rw_ff |-> hi_ff == 4'(HALF_RD))
    else $error("read frame clocked too fast");
  a_sdi_steady:
    assert property (!sync_n_in && sclk_in && $past(sclk_in) |->
                     $stable(sdi_in))
    else $error("data changed while clock high");
  a_lead_zero:
    assert property ($fell(sclk_in) && !sync_n_in && prev_rd_ff &&
                     edge_ff <= 5'h08 |-> !sdo_in)
    else $error("readback leading bits not zero");
  a_idle_clock:
    assert property (sync_n_in && $past(sync_n_in) |-> !sclk_in)
    else $error("clock moved outside a frame");

  c_read_frame: cover property ($fell(sync_n_in) ##1 rw_ff);
  c_collect: cover property ($fell(sclk_in) && prev_rd_ff);
  c_busy_end: cover property ($rose(busy_n_in));
endmodule
`default_nettype wire

//--- sim/test_dps_readback_switch_control.sv
// Bench joining host and device ends, driving the host command port.
`default_nettype none
module test_dps_readback_switch_control
  import drs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0;
  logic reset_n_in, reset_pin_n, hardware_output_inhibit_pin_n, comp_high, comp_low;
  logic [4:0] alarm_ev;
  logic [1:0] sw01, sw02, sw05;
  logic [9:0] closed;
  logic [2:0] oe, apin, addr;
  logic [15:0] wdata, rdata;
  logic wr, rd;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [6:0] dflt_addr [9] = '{REG_FORCE_X1, REG_FORCE_M, REG_FORCE_C,
    REG_CPL_X1, REG_CPL_M, REG_CPL_C, REG_CPH_X1, REG_CPH_C, 7'h4b};
  logic [15:0] dflt_val [9] = '{16'h0000, 16'hffff, 16'h8000, 16'h0000,
    16'hffff, 16'h8000, 16'hffff, 16'h8000, 16'h0000};
  logic [1:0] g05 [4] = '{POS_A, POS_B, POS_OPEN, POS_OPEN};
  logic [1:0] g02 [4] = '{POS_A, POS_A, POS_C, POS_B};
  logic [1:0] g01 [4] = '{POS_B, POS_B, POS_C, POS_C};

  drs_if link_if();
  drs_device drs_device_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .link(link_if.device), .reset_pin_n_in(reset_pin_n),
    .hw_inhibit_n_in(hardware_output_inhibit_pin_n), .comp_high_in(comp_high),
    .comp_low_in(comp_low), .alarm_event_in(alarm_ev),
    .sw01_pos_out(sw01), .sw02_pos_out(sw02), .sw05_pos_out(sw05),
    .sw_closed_out(closed), .alarm_pin_oe_out(oe), .alarm_pin_out(apin));
  drs_host #(.HALF_WR(HALF_WRITE), .HALF_RD(HALF_READ)) drs_host_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .link(link_if.host),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata));
  drs_monitor #(.HALF_RD(HALF_READ)) drs_monitor_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .sclk_in(link_if.sclk),
    .sync_n_in(link_if.sync_n), .sdi_in(link_if.sdi),
    .sdo_in(link_if.sdo), .busy_n_in(link_if.busy_n));

  // Free-running system clock.
  always #10 clk_in = ~clk_in;

  // Hang guard: a run this long means a handshake never came.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic sw_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic sw_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    // Take the data mid-cycle, then return on a rising edge.
    @(negedge clk_in);
    d = rdata;
    @(posedge clk_in);
  endtask

  task automatic wait_ready();
    logic [15:0] st;
    for (int i = 0; i < 200; i++) begin
      sw_rd(HREG_STATUS, st);
      if (st[1] === 1'b1) break;
    end
    check({15'h0, st[1]}, 16'h0001);
  endtask

  // One frame, then wait for the host to go idle and the device to apply.
  task automatic frame(input logic rw, input logic [6:0] a,
                       input logic [15:0] d);
    logic [15:0] st;
    sw_wr(HREG_DATA, d);
    sw_wr(HREG_CMD, {8'h00, rw, a});
    for (int i = 0; i < 400; i++) begin
      sw_rd(HREG_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    repeat (6) @(posedge clk_in);
  endtask

  task automatic read_reg(input logic [6:0] a, output logic [15:0] d);
    frame(1'b1, a, 16'h0000);
    frame(1'b1, REG_SYS_CTRL, 16'h0000);
    sw_rd(HREG_RX, d);
  endtask

  task automatic t_defaults();
    logic [15:0] d;
    for (int i = 0; i < 9; i++) begin
      read_reg(dflt_addr[i], d);
      check(d, dflt_val[i]);
    end
    check({14'h0, sw02}, {14'h0, POS_C});
    check({14'h0, sw01}, {14'h0, POS_B});
  endtask

  task automatic t_write_read();
    logic [15:0] d;
    frame(1'b0, REG_FORCE_M, 16'h1234);
    frame(1'b0, REG_CPH_C, 16'hedcb);
    read_reg(REG_FORCE_M, d);
    check(d, 16'h1234);
    read_reg(REG_CPH_C, d);
    check(d, 16'hedcb);
  endtask

  task automatic t_comp();
    logic [15:0] d;
    comp_high <= 1'b1;
    repeat (4) @(posedge clk_in);
    read_reg(REG_COMP_STATUS, d);
    check(d, 16'h0010);
    frame(1'b0, REG_COMP_STATUS, 16'hffff);
    comp_high <= 1'b0;
    comp_low <= 1'b1;
    repeat (4) @(posedge clk_in);
    read_reg(REG_COMP_STATUS, d);
    check(d, 16'h0020);
    comp_low <= 1'b0;
  endtask

  task automatic t_alarm();
    logic [15:0] d;
    alarm_ev <= 5'h0d;
    repeat (4) @(posedge clk_in);
    alarm_ev <= 5'h00;
    repeat (6) @(posedge clk_in);
    check({13'h0, oe}, 16'h0007);
    frame(1'b0, REG_ALARM_STATUS, 16'h0000);
    check({13'h0, oe}, 16'h0007);
    read_reg(REG_ALARM_STATUS, d);
    check(d, 16'h75c0);
    check({13'h0, oe}, 16'h0000);
    check({13'h0, apin}, 16'h0000);
    read_reg(REG_ALARM_STATUS, d);
    check(d, 16'hffc0);
  endtask

  task automatic t_switches();
    logic [9:0] e;
    for (int r = 0; r < 7; r++) begin
      frame(1'b0, REG_DPS1, 16'h8000 | 16'(r << 10) | 16'(r << 4));
      e = 10'h000;
      e[SWC_16] = (r != 0);
      e[SWC_04] = (r < 5);
      e[SWC_07] = (r < 5);
      e[SWC_15] = (r >= 5);
      e[SWC_14] = (r == 5);
      e[SWC_13] = (r == 6);
      check({6'h0, closed}, {6'h0, e});
      check({14'h0, sw02}, {14'h0, POS_A});
    end
    frame(1'b0, REG_DPS1, 16'h0000);
    check({14'h0, sw02}, {14'h0, POS_C});
    frame(1'b0, REG_DPS1, 16'h8000);
    hardware_output_inhibit_pin_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    check({14'h0, sw02}, {14'h0, POS_C});
    hardware_output_inhibit_pin_n <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      frame(1'b0, REG_DPS2, 16'(g << 1) | 16'(g & 1) | 16'((g & 1) << 3));
      e = 10'h000;
      e[SWC_04] = 1'b1;
      e[SWC_07] = 1'b1;
      e[SWC_06] = g[1];
      e[SWC_08] = g[0];
      e[SWC_09] = g[0];
      e[SWC_11] = g[0];
      check({6'h0, closed}, {6'h0, e});
      check({14'h0, sw05}, {14'h0, g05[g]});
      check({14'h0, sw02}, {14'h0, g02[g]});
      check({14'h0, sw01}, {14'h0, g01[g]});
    end
    frame(1'b0, REG_DPS2, 16'h0000);
    frame(1'b0, REG_SYS_CTRL, 16'h0001);
    check({14'h0, sw01}, {14'h0, POS_A});
  endtask

  // A second pulse during the load must not restart it.
  task automatic t_reset_func();
    logic [15:0] d;
    frame(1'b0, REG_FORCE_C, 16'h1111);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_pin_n <= 1'b1;
    repeat (20) @(posedge clk_in);
    check({15'h0, link_if.busy_n}, 16'h0000);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_pin_n <= 1'b1;
    wait_ready();
    read_reg(REG_FORCE_C, d);
    check(d, 16'h8000);
    check({14'h0, sw02}, {14'h0, POS_C});
    check({6'h0, closed}, 16'h0005);
  endtask

  // Main sequence; the reset pin is held low into the power-on load.
  initial begin
    reset_n_in = 1'b0;
    reset_pin_n = 1'b0;
    hardware_output_inhibit_pin_n = 1'b1;
    comp_high = 1'b0;
    comp_low = 1'b0;
    alarm_ev = 5'h00;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (30) @(posedge clk_in);
    reset_pin_n <= 1'b1;
    wait_ready();
    t_defaults();
    t_write_read();
    t_comp();
    t_alarm();
    t_switches();
    t_reset_func();
    end_of_test();
  end
endmodule
`default_nettype wire
